/* File: drs_map.vh */
// drs_map.vh: object indices, warning bit positions, state codes, limits
// assumes: included by the runtime status object files of the drive
`ifndef DRS_MAP_VH
`define DRS_MAP_VH

`define DRS_IDX_WARNING      16'h2003
`define DRS_IDX_STATE        16'h2004
`define DRS_IDX_TEMP_DRIVE   16'h2030
`define DRS_IDX_TEMP_MOTOR   16'h2031
`define DRS_IDX_TEMP_SINK    16'h2032
`define DRS_IDX_BUS_VOLT     16'h2041
`define DRS_IDX_TORQUE_CUR   16'h2050
`define DRS_IDX_CONTROL_WORD 16'h6040

`define DRS_CW_FAULT_RESET   7
`define DRS_WARN_USED        14
`define DRS_WARN_RESET       32'h0000_0000

`define DRS_W_GUARD          0
`define DRS_W_OVERLOAD       1
`define DRS_W_STORE_OFF      2
`define DRS_W_UPDATE_DENY    3
`define DRS_W_FACTORY_BLANK  4
`define DRS_W_ALARM_OFF      5
`define DRS_W_COMM_DEFAULT   6
`define DRS_W_DAC_BAD        7
`define DRS_W_TEMP_SINK      8
`define DRS_W_TEMP_LOGIC     9
`define DRS_W_TEMP_MOTOR     10
`define DRS_W_CAN_ERR        11
`define DRS_W_TQ_FUNC        12
`define DRS_W_TQ_LIMIT       13

`define DRS_ST_NOT_READY     16'h0000
`define DRS_ST_SAFETY        16'h0001
`define DRS_ST_STOP          16'h0002
`define DRS_ST_RUN           16'h0003
`define DRS_ST_STANDBY       16'h0004
`define DRS_ST_BRAKE_SHORT   16'h0005
`define DRS_ST_SW_DISABLED   16'h000a
`define DRS_ST_READY         16'h000b
`define DRS_ST_FAULT_REACT   16'h0010
`define DRS_ST_FAULT         16'h0011
`define DRS_ST_ERROR         16'h0012

`define DRS_TDRV_MIN         16'hff6a
`define DRS_TDRV_MAX         16'h04e2
`define DRS_TMOT_MIN         16'hfe70
`define DRS_TMOT_MAX         16'h0514
`define DRS_VBUS_MAX         16'h2af8
`define DRS_TQ_MIN           16'h8001
`define DRS_TQ_MAX           16'h7fff

`define DRS_ABORT_READ_ONLY  32'h0601_0002
`define DRS_ABORT_NO_OBJECT  32'h0602_0000

`endif

/* File: drs_clamp.v */
// drs_clamp.v: registered signed clamp of one measurement to its range
// assumes: bounds are constants; input is on the same clock
`timescale 1ns/1ns
module drs_clamp #(
  parameter [15:0] MIN_VAL = 16'h8001,
  parameter [15:0] MAX_VAL = 16'h7fff
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [15:0] raw,
  output reg  [15:0] clamped_r
);
  // out-of-range front-end values are pinned, never passed on
  wire signed [15:0] raw_s = raw;
  wire signed [15:0] min_s = MIN_VAL;
  wire signed [15:0] max_s = MAX_VAL;
  reg         [15:0] clamped_nxt;

  always @* begin
    if (raw_s < min_s)
      clamped_nxt = MIN_VAL;
    else if (raw_s > max_s)
      clamped_nxt = MAX_VAL;
    else
      clamped_nxt = raw;
  end

  always @(posedge clk) begin
    if (!reset_n)
      clamped_r <= 16'h0000;
    else
      clamped_r <= clamped_nxt;
  end
endmodule // drs_clamp

/* File: drs_status.v */
// drs_status.v: runtime monitoring objects of the drive, read by SDO
// assumes: SDO decode upstream delivers one-cycle read/write requests
// with a 16-bit object index; sources are same clock unless noted
//
// Functional notes
// - fault reset bit 7 clears all warnings except those whose source is still active
// - 32-bit read-only warning word, bits 14-31 zero
// - bit 0: node guarding message lost
// - bit 1: overload energy limit active
// - bit 2: store/restore/load commands disabled
// - bit 3: network parameter update refused
// - bit 4: factory area blank
// - bit 5: network alarms disabled
// - bit 6: comm objects set to defaults
// - bit 7: converter configuration invalid
// - bits 8,9,10: sink, logic, motor temperature
// - bit 11: CAN error passive or bus-off
// - bit 12 limit enabled, bit 13 limiting
// - codes 2 stop, 3 run, 4 standby
// - codes 0, 10, 11 init substates
// - codes 16, 17, 18 fault substates
// - code 1 safety, 5 braking short
// - drive temperature -150..1250 tenths degree
// - motor temperature -400..1300 tenths degree
// - heat sink temperature -400..1300
// - bus voltage 0..11000 hundredths volt
// - torque current -32767..32767 hundredths amp
`timescale 1ns/1ns
`include "drs_map.vh"
module drs_status (
  input  wire        clk,
  input  wire        reset_n,
  // sdo object access
  input  wire        obj_rd,
  input  wire        obj_wr,
  input  wire [15:0] obj_index,
  input  wire [31:0] obj_wdata,
  output reg         obj_ack_r,
  output reg         obj_abort_r,
  output reg  [31:0] obj_abort_code_r,
  output reg  [31:0] obj_rdata_r,
  // warning sources, levels
  input  wire        guard_lost,
  input  wire        overload_energy_limit,
  input  wire        store_disabled,
  input  wire        update_refused,
  input  wire        factory_blank,
  input  wire        alarm_report_off,
  input  wire        comm_default_init,
  input  wire        dac_config_bad,
  input  wire        temp_sink_warn,
  input  wire        temp_logic_warn,
  input  wire        temp_motor_warn,
  input  wire        can_error_pin,
  input  wire        torque_limit_on,
  input  wire        torque_limiting,
  // drive state machine condition, one-hot select
  input  wire [10:0] state_sel,
  // raw measurements
  input  wire [15:0] drive_temp_raw,
  input  wire [15:0] motor_temp_raw,
  input  wire [15:0] sink_temp_raw,
  input  wire [15:0] bus_volt_raw,
  input  wire [15:0] torque_cur_raw,
  // mirrors of the objects
  output reg  [31:0] warning_log_r,
  output reg  [15:0] drive_state_code_r
);

  localparam [10:0] S_NOT_READY  = 11'h001;
  localparam [10:0] S_SAFETY     = 11'h002;
  localparam [10:0] S_STOP       = 11'h004;
  localparam [10:0] S_RUN        = 11'h008;
  localparam [10:0] S_STANDBY    = 11'h010;
  localparam [10:0] S_BRAKE      = 11'h020;
  localparam [10:0] S_SW_DIS     = 11'h040;
  localparam [10:0] S_READY      = 11'h080;
  localparam [10:0] S_FLT_REACT  = 11'h100;
  localparam [10:0] S_FAULT      = 11'h200;
  localparam [10:0] S_ERROR      = 11'h400;

  // the CAN error line comes from the controller pin domain
  reg         can_err_s1_r;
  reg         can_err_s2_r;
  wire [13:0] warn_src;
  reg  [31:0] warning_nxt;
  reg  [15:0] state_nxt;
  wire [15:0] tdrv_q;
  wire [15:0] tmot_q;
  wire [15:0] tsnk_q;
  wire [15:0] vbus_q;
  wire [15:0] tqc_q;
  wire        fault_reset;
  integer     i;

  function is_status_obj;
    input [15:0] idx;
    begin
      is_status_obj = (idx == `DRS_IDX_WARNING) ||
                      (idx == `DRS_IDX_STATE) ||
                      (idx == `DRS_IDX_TEMP_DRIVE) ||
                      (idx == `DRS_IDX_TEMP_MOTOR) ||
                      (idx == `DRS_IDX_TEMP_SINK) ||
                      (idx == `DRS_IDX_BUS_VOLT) ||
                      (idx == `DRS_IDX_TORQUE_CUR);
    end
  endfunction

  always @(posedge clk) begin
    if (!reset_n) begin
      can_err_s1_r <= 1'b0;
      can_err_s2_r <= 1'b0;
    end else begin
      can_err_s1_r <= can_error_pin;
      can_err_s2_r <= can_err_s1_r;
    end
  end

  assign warn_src[`DRS_W_GUARD]         = guard_lost;
  assign warn_src[`DRS_W_OVERLOAD]      = overload_energy_limit;
  assign warn_src[`DRS_W_STORE_OFF]     = store_disabled;
  assign warn_src[`DRS_W_UPDATE_DENY]   = update_refused;
  assign warn_src[`DRS_W_FACTORY_BLANK] = factory_blank;
  assign warn_src[`DRS_W_ALARM_OFF]     = alarm_report_off;
  assign warn_src[`DRS_W_COMM_DEFAULT]  = comm_default_init;
  assign warn_src[`DRS_W_DAC_BAD]       = dac_config_bad;
  assign warn_src[`DRS_W_TEMP_SINK]     = temp_sink_warn;
  assign warn_src[`DRS_W_TEMP_LOGIC]    = temp_logic_warn;
  assign warn_src[`DRS_W_TEMP_MOTOR]    = temp_motor_warn;
  assign warn_src[`DRS_W_CAN_ERR]       = can_err_s2_r;
  assign warn_src[`DRS_W_TQ_FUNC]       = torque_limit_on;
  assign warn_src[`DRS_W_TQ_LIMIT]      = torque_limiting;

  assign fault_reset = obj_wr &&
                       (obj_index == `DRS_IDX_CONTROL_WORD) &&
                       obj_wdata[`DRS_CW_FAULT_RESET];

  // clear first, then set: a condition still present survives the reset
  always @* begin
    warning_nxt = warning_log_r;
    if (fault_reset)
      warning_nxt = `DRS_WARN_RESET;
    for (i = 0; i < `DRS_WARN_USED; i = i + 1) begin
      if (warn_src[i])
        warning_nxt[i] = 1'b1;
    end
    warning_nxt[31:`DRS_WARN_USED] = 18'h00000;
  end

  always @* begin
    case (state_sel)
      S_NOT_READY: state_nxt = `DRS_ST_NOT_READY;
      S_SAFETY:    state_nxt = `DRS_ST_SAFETY;
      S_STOP:      state_nxt = `DRS_ST_STOP;
      S_RUN:       state_nxt = `DRS_ST_RUN;
      S_STANDBY:   state_nxt = `DRS_ST_STANDBY;
      S_BRAKE:     state_nxt = `DRS_ST_BRAKE_SHORT;
      S_SW_DIS:    state_nxt = `DRS_ST_SW_DISABLED;
      S_READY:     state_nxt = `DRS_ST_READY;
      S_FLT_REACT: state_nxt = `DRS_ST_FAULT_REACT;
      S_FAULT:     state_nxt = `DRS_ST_FAULT;
      S_ERROR:     state_nxt = `DRS_ST_ERROR;
      // a malformed select holds the last code rather than invent one
      default:     state_nxt = drive_state_code_r;
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      warning_log_r      <= `DRS_WARN_RESET;
      drive_state_code_r <= `DRS_ST_NOT_READY;
    end else begin
      warning_log_r      <= warning_nxt;
      drive_state_code_r <= state_nxt;
    end
  end

  drs_clamp #(.MIN_VAL(`DRS_TDRV_MIN), .MAX_VAL(`DRS_TDRV_MAX)) u_tdrv (
    .clk       (clk),
    .reset_n   (reset_n),
    .raw       (drive_temp_raw),
    .clamped_r (tdrv_q)
  );

  drs_clamp #(.MIN_VAL(`DRS_TMOT_MIN), .MAX_VAL(`DRS_TMOT_MAX)) u_tmot (
    .clk       (clk),
    .reset_n   (reset_n),
    .raw       (motor_temp_raw),
    .clamped_r (tmot_q)
  );

  drs_clamp #(.MIN_VAL(`DRS_TMOT_MIN), .MAX_VAL(`DRS_TMOT_MAX)) u_tsnk (
    .clk       (clk),
    .reset_n   (reset_n),
    .raw       (sink_temp_raw),
    .clamped_r (tsnk_q)
  );

  drs_clamp #(.MIN_VAL(16'h0000), .MAX_VAL(`DRS_VBUS_MAX)) u_vbus (
    .clk       (clk),
    .reset_n   (reset_n),
    .raw       (bus_volt_raw),
    .clamped_r (vbus_q)
  );

  drs_clamp #(.MIN_VAL(`DRS_TQ_MIN), .MAX_VAL(`DRS_TQ_MAX)) u_tqc (
    .clk       (clk),
    .reset_n   (reset_n),
    .raw       (torque_cur_raw),
    .clamped_r (tqc_q)
  );

  // answers one cycle after the request; the control word write is
  // acknowledged here only as far as the fault reset goes
  always @(posedge clk) begin
    if (!reset_n) begin
      obj_ack_r        <= 1'b0;
      obj_abort_r      <= 1'b0;
      obj_abort_code_r <= 32'h0000_0000;
      obj_rdata_r      <= 32'h0000_0000;
    end else begin
      obj_ack_r        <= 1'b0;
      obj_abort_r      <= 1'b0;
      obj_abort_code_r <= 32'h0000_0000;
      if (obj_wr) begin
        if (obj_index == `DRS_IDX_CONTROL_WORD) begin
          obj_ack_r <= 1'b1;
        end else if (is_status_obj(obj_index)) begin
          obj_abort_r      <= 1'b1;
          obj_abort_code_r <= `DRS_ABORT_READ_ONLY;
        end else begin
          obj_abort_r      <= 1'b1;
          obj_abort_code_r <= `DRS_ABORT_NO_OBJECT;
        end
      end else if (obj_rd) begin
        case (obj_index)
          `DRS_IDX_WARNING: begin
            obj_ack_r   <= 1'b1;
            obj_rdata_r <= warning_log_r;
          end
          `DRS_IDX_STATE: begin
            obj_ack_r   <= 1'b1;
            obj_rdata_r <= {16'h0000, drive_state_code_r};
          end
          `DRS_IDX_TEMP_DRIVE: begin
            obj_ack_r   <= 1'b1;
            obj_rdata_r <= {{16{tdrv_q[15]}}, tdrv_q};
          end
          `DRS_IDX_TEMP_MOTOR: begin
            obj_ack_r   <= 1'b1;
            obj_rdata_r <= {{16{tmot_q[15]}}, tmot_q};
          end
          `DRS_IDX_TEMP_SINK: begin
            obj_ack_r   <= 1'b1;
            obj_rdata_r <= {{16{tsnk_q[15]}}, tsnk_q};
          end
          `DRS_IDX_BUS_VOLT: begin
            obj_ack_r   <= 1'b1;
            obj_rdata_r <= {16'h0000, vbus_q};
          end
          `DRS_IDX_TORQUE_CUR: begin
            obj_ack_r   <= 1'b1;
            obj_rdata_r <= {{16{tqc_q[15]}}, tqc_q};
          end
          default: begin
            obj_abort_r      <= 1'b1;
            obj_abort_code_r <= `DRS_ABORT_NO_OBJECT;
          end
        endcase
      end
    end
  end
endmodule // drs_status

/* File: drs_sdo_master.sv */
// drs_sdo_master.sv: network master model issuing object reads/writes
// assumes: bench calls xfer 2 ns after a rising edge of clk
`timescale 1ns/1ns
module drs_sdo_master (
  input  logic        clk,
  output logic        obj_rd,
  output logic        obj_wr,
  output logic [15:0] obj_index,
  output logic [31:0] obj_wdata
);
  initial begin
    obj_rd = 1'b0;
    obj_wr = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 32'h0000_0000;
  end
  // released lines show inverted values so stale ones never pass as held
  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [31:0] d);
    obj_rd = !w;
    obj_wr = w;
    obj_index = idx;
    obj_wdata = d; // bit 7 of a control write is fault reset
    @(posedge clk);
    #2;
    obj_rd = 1'b0;
    obj_wr = 1'b0;
    obj_index = ~idx;
    obj_wdata = ~d;
    @(posedge clk);
    #2;
  endtask
endmodule // drs_sdo_master

/* File: drs_status_checker.sv */
// drs_status_checker.sv: port assertions for the status objects
// assumes: bound to drs_status, one clock, synchronous reset_n
`timescale 1ns/1ns
module drs_status_checker (
  input logic        clk,
  input logic        reset_n,
  input logic        obj_rd,
  input logic        obj_wr,
  input logic [15:0] obj_index,
  input logic [31:0] obj_wdata,
  input logic        obj_ack_r,
  input logic        obj_abort_r,
  input logic [31:0] obj_abort_code_r,
  input logic        guard_lost,
  input logic        torque_limiting,
  input logic [10:0] state_sel,
  input logic [31:0] warning_log_r,
  input logic [15:0] drive_state_code_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire clr = obj_wr && obj_index == 16'h6040 && obj_wdata[7];
  AST_ANSWER: assert property (
    (obj_rd || obj_wr) |=> obj_ack_r ^ obj_abort_r)
    else $error("request without single answer");
  AST_QUIET: assert property (
    !(obj_rd || obj_wr) |=> !(obj_ack_r || obj_abort_r))
    else $error("answer without request");
  AST_RO_ABORT: assert property (
    obj_wr && obj_index inside {16'h2003, 16'h2004, 16'h2030, 16'h2031,
      16'h2032, 16'h2041, 16'h2050}
    |=> obj_abort_r && obj_abort_code_r == 32'h0601_0002)
    else $error("read-only write not aborted");
  AST_HIGH_ZERO: assert property (
    warning_log_r[31:14] == 18'h0)
    else $error("unused warning bit set");
  AST_STICKY: assert property (
    !clr |=> (warning_log_r & $past(warning_log_r)) == $past(warning_log_r))
    else $error("warning lost without fault reset");
  AST_GUARD: assert property (
    guard_lost |=> warning_log_r[0])
    else $error("guarding warning not set");
  AST_TQ: assert property (
    torque_limiting |=> warning_log_r[13])
    else $error("torque limiting warning not set");
  AST_CLEAR: assert property (
    clr && !guard_lost |=> !warning_log_r[0])
    else $error("fault reset did not clear");
  AST_RUN: assert property (
    state_sel == 11'h008 |=> drive_state_code_r == 16'h0003)
    else $error("run code wrong");
  AST_FAULT: assert property (
    state_sel == 11'h200 |=> drive_state_code_r == 16'h0011)
    else $error("fault code wrong");
endmodule // drs_status_checker
bind drs_status drs_status_checker i_drs_status_checker (.clk, .reset_n,
  .obj_rd, .obj_wr, .obj_index, .obj_wdata, .obj_ack_r, .obj_abort_r,
  .obj_abort_code_r, .guard_lost, .torque_limiting, .state_sel,
  .warning_log_r, .drive_state_code_r);

/* File: tb_drive_runtime_status_objects.sv */
// tb_drive_runtime_status_objects.sv: self-checking bench of drs_status
// assumes: drs_sdo_master as network side, checker bound to the design
`timescale 1ns/1ns
module tb_drive_runtime_status_objects;
  logic        clk;
  logic        reset_n;
  logic        obj_rd;
  logic        obj_wr;
  logic [15:0] obj_index;
  logic [31:0] obj_wdata;
  logic        obj_ack_r;
  logic        obj_abort_r;
  logic [31:0] obj_abort_code_r;
  logic [31:0] obj_rdata_r;
  logic [13:0] src;
  logic [10:0] state_sel;
  logic [15:0] raw [5];
  logic [31:0] warning_log_r;
  logic [15:0] drive_state_code_r;
  logic [32:0] expq [$];
  logic [31:0] last_rd;
  logic [31:0] wexp;
  integer      miscompares;
  integer      n_tests;
  int          codes [11] = '{0, 1, 2, 3, 4, 5, 10, 11, 16, 17, 18};
  int          lo [5] = '{-150, -400, -400, 0, -32767};
  int          hi [5] = '{1250, 1300, 1300, 11000, 32767};
  logic [15:0] ro [7] = '{16'h2003, 16'h2004, 16'h2030, 16'h2031,
                          16'h2032, 16'h2041, 16'h2050};
  drs_sdo_master i_drs_sdo_master (.clk(clk), .obj_rd(obj_rd),
    .obj_wr(obj_wr), .obj_index(obj_index), .obj_wdata(obj_wdata));
  drs_status i_drs_status (.clk(clk), .reset_n(reset_n), .obj_rd(obj_rd),
    .obj_wr(obj_wr), .obj_index(obj_index), .obj_wdata(obj_wdata),
    .obj_ack_r(obj_ack_r), .obj_abort_r(obj_abort_r),
    .obj_abort_code_r(obj_abort_code_r), .obj_rdata_r(obj_rdata_r),
    .guard_lost(src[0]), .overload_energy_limit(src[1]),
    .store_disabled(src[2]), .update_refused(src[3]),
    .factory_blank(src[4]), .alarm_report_off(src[5]),
    .comm_default_init(src[6]), .dac_config_bad(src[7]),
    .temp_sink_warn(src[8]), .temp_logic_warn(src[9]),
    .temp_motor_warn(src[10]), .can_error_pin(src[11]),
    .torque_limit_on(src[12]), .torque_limiting(src[13]),
    .state_sel(state_sel), .drive_temp_raw(raw[0]),
    .motor_temp_raw(raw[1]), .sink_temp_raw(raw[2]),
    .bus_volt_raw(raw[3]), .torque_cur_raw(raw[4]),
    .warning_log_r(warning_log_r),
    .drive_state_code_r(drive_state_code_r));
  task automatic report_and_stop;
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic req(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, input logic [32:0] e);
    expq.push_back(e);
    if (!w && !e[32]) last_rd = e[31:0];
    i_drs_sdo_master.xfer(w, idx, d);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] e);
    req(1'b0, idx, $urandom, {1'b0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // clamp kept here so a wrong bound in the design cannot hide
  function automatic logic [31:0] clp(input logic [15:0] r, input int k);
    int v;
    v = $signed(r);
    if (v < lo[k]) v = lo[k];
    if (v > hi[k]) v = hi[k];
    return {{16{v[15]}}, v[15:0]};
  endfunction
  // answers are looked at mid-cycle, well clear of the launching edge
  always @(negedge clk) begin
    if (obj_ack_r === 1'b1 || obj_abort_r === 1'b1) begin
      wexp = obj_abort_r ? obj_abort_code_r : obj_rdata_r;
      chk({obj_abort_r, wexp},
          expq.size() ? expq.pop_front() : 'x);
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  logic [31:0] wlog;
  initial begin
    miscompares = 0;
    n_tests = 0;
    reset_n = 1'b0;
    src = '0;
    state_sel = 11'h001;
    foreach (raw[k]) raw[k] = 16'h0000;
    void'($urandom(32'h867a4dc8));
    tick(8);
    reset_n = 1'b1;
    wlog = '0;
    for (int r = 0; r < 6; r++) begin
      src = 14'($urandom);
      wlog = wlog | {18'h0, src};
      tick(1);
      src = '0;
      tick(4);
      rd(16'h2003, wlog);
      chk({1'b0, warning_log_r}, {1'b0, wlog});
      req(1'b1, 16'h6040, $urandom & 32'hffff_ff7f,
          {1'b0, last_rd});
      rd(16'h2003, wlog);
      if (r % 2 == 1) begin
        req(1'b1, 16'h6040, $urandom | 32'h80, {1'b0, last_rd});
        wlog = '0;
        rd(16'h2003, wlog);
      end
    end
    // a source still high in the clearing cycle keeps its bit
    src = 14'h0001;
    req(1'b1, 16'h6040, 32'h0000_0080, {1'b0, last_rd});
    src = '0;
    wlog = 32'h0000_0001;
    rd(16'h2003, wlog);
    for (int r = 0; r < 6; r++) begin
      foreach (raw[k]) raw[k] = r == 0 ? 16'h8000 : r == 1 ? 16'h7fff
                                : 16'($urandom);
      tick(3);
      foreach (raw[k])
        rd(ro[k+2], clp(raw[k], k));
    end
    foreach (codes[k]) begin
      state_sel = 11'h001 << k;
      tick(2);
      rd(16'h2004, codes[k]);
      chk({17'h0, drive_state_code_r}, 33'(codes[k]));
    end
    // a select that is not one-hot keeps the last code
    state_sel = 11'h003;
    tick(2);
    rd(16'h2004, 32'h0000_0012);
    foreach (ro[k])
      req(1'b1, ro[k], $urandom, {1'b1, 32'h0601_0002});
    rd(16'h2050, clp(raw[4], 4));
    rd(16'h2003, wlog);
    req(1'b0, 16'h2051, 32'h0, {1'b1, 32'h0602_0000});
    req(1'b1, 16'h2051, $urandom, {1'b1, 32'h0602_0000});
    tick(4);
    if (expq.size() != 0) miscompares++;
    report_and_stop;
  end
endmodule // tb_drive_runtime_status_objects
